// file: hw/ppl_regs.svh
// register indices, field positions, reset values and timing constants
`ifndef PPL_REGS_SVH
`define PPL_REGS_SVH
// package domain base, relative indices and the absolute unit index
`define PPL_PKG_BASE   8'h10
`define PPL_REL_LIMIT  8'h00
`define PPL_REL_ENERGY 8'h01
`define PPL_REL_POLICY 8'h02
`define PPL_REL_THROT  8'h03
`define PPL_REL_INFO   8'h04
`define PPL_UNIT_IDX   8'h06
// limit-control layout: one 24-bit half per limit
`define PPL_HALF_W     24
`define PPL_L1_LSB     0
`define PPL_L2_LSB     32
`define PPL_LOCK_BIT   63
`define PPL_W2_LSB     49
`define PPL_W2_MSB     55
`define PPL_CTRL_MASK  64'h80FF_FFFF_00FF_FFFF
`define PPL_W2_FIXED   7'h0A
// unit-scale layout and defaults
`define PPL_PU_LSB     0
`define PPL_PU_MSB     3
`define PPL_ESU_LSB    8
`define PPL_ESU_MSB    12
`define PPL_TU_LSB     16
`define PPL_TU_MSB     19
`define PPL_PU_DEF     4'h3
`define PPL_ESU_DEF    5'h10
`define PPL_TU_DEF     4'hA
// range-info layout and built-in values
`define PPL_TDP_LSB    0
`define PPL_MINP_LSB   16
`define PPL_MAXP_LSB   32
`define PPL_MAXW_LSB   48
`define PPL_TDP_VAL    15'h0280
`define PPL_MINP_VAL   15'h0100
`define PPL_MAXP_VAL   15'h0400
`define PPL_MAXW_VAL   6'h20
// counter width for energy and throttled time
`define PPL_CNT_W      32
// timing: times in ns, cycle counts derived from the clock period
`define PPL_CLK_NS     4
`define PPL_REFRESH_NS 1000000
`define PPL_TUNIT_NS   976000
// window fraction digits are tenths
`define PPL_TENTHS     10
`endif

// file: hw/ppl_pkg.sv
// types shared by the package power limit register block
package ppl_pkg;
  // one limit, laid out exactly as its half of the control register
  typedef struct packed {
    logic [1:0]  win_frac;
    logic [4:0]  win_exp;
    logic        clamp;
    logic        en;
    logic [14:0] ceiling;
  } ppl_limit_s;

  // register port request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  idx;
    logic [63:0] wdata;
  } ppl_req_s;

  // power estimator sample into the block
  typedef struct packed {
    logic        energy_vld;
    logic [15:0] energy_amt;
    logic [14:0] avg_power;
  } ppl_meter_s;
endpackage : ppl_pkg

// file: hw/ppl_limit_regs.sv
// package power limit registers, window checker and counters
`timescale 1ns/10ps
`include "ppl_regs.svh"
module ppl_limit_regs #(
  parameter int  REFRESH_CYC = `PPL_REFRESH_NS / `PPL_CLK_NS,
  parameter int  TUNIT_CYC   = `PPL_TUNIT_NS / `PPL_CLK_NS,
  parameter bit  W2_FIXED    = 1'b0
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire ppl_pkg::ppl_req_s   req_in,
  input  wire ppl_pkg::ppl_meter_s meter_in,
  input  wire logic                os_below_in,
  output logic [63:0]              rdata_out,
  output logic                     ack_out,
  output logic                     fault_out,
  output logic                     pstate_down_out,
  output logic                     below_req_ok_out
);
  localparam int CW = `PPL_CNT_W;

  // 2^y * (1 + f/10) time units, saturated to the counter width
  function automatic logic [CW-1:0] win_len(
    input logic [4:0] y,
    input logic [1:0] f
  );
    logic [39:0] t;
    t = ((40'h1 << y) * (40'(`PPL_TENTHS) + 40'(f)))
        / 40'(`PPL_TENTHS);
    win_len = (t[39:CW] != '0) ? '1 : t[CW-1:0];
  endfunction : win_len

  function automatic logic [7:0] abs_idx(input logic [7:0] rel);
    abs_idx = `PPL_PKG_BASE + rel;
  endfunction : abs_idx

  logic [63:0]   ctrl_r;
  logic [63:0]   ctrl_nxt;
  logic [CW-1:0] energy_r;
  logic [CW-1:0] pend_r;
  logic [CW-1:0] throt_r;
  logic [31:0]   ref_cnt_r;
  logic [31:0]   tu_cnt_r;
  logic          ref_tick_r;
  logic          tu_tick_r;
  logic [63:0]   rdata_r;
  logic          ack_r;
  logic          fault_r;
  logic          down_r;
  logic          below_r;

  // decode
  wire hit_limit  = req_in.idx == abs_idx(`PPL_REL_LIMIT);
  wire hit_energy = req_in.idx == abs_idx(`PPL_REL_ENERGY);
  wire hit_throt  = req_in.idx == abs_idx(`PPL_REL_THROT);
  wire hit_info   = req_in.idx == abs_idx(`PPL_REL_INFO);
  wire hit_unit   = req_in.idx == `PPL_UNIT_IDX;
  // the reserved policy slot falls through to a fault
  wire mapped = hit_limit | hit_energy | hit_throt
              | hit_info | hit_unit;
  wire access = req_in.rd | req_in.wr;
  wire locked = ctrl_r[`PPL_LOCK_BIT];
  // only the limit register takes writes, and only while unlocked
  wire ctrl_we = req_in.wr & hit_limit & ~locked;

  // read values
  wire [63:0] unit_val =
      (64'(`PPL_TU_DEF)  << `PPL_TU_LSB)
    | (64'(`PPL_ESU_DEF) << `PPL_ESU_LSB)
    | (64'(`PPL_PU_DEF)  << `PPL_PU_LSB);
  wire [63:0] info_val =
      (64'(`PPL_TDP_VAL)  << `PPL_TDP_LSB)
    | (64'(`PPL_MINP_VAL) << `PPL_MINP_LSB)
    | (64'(`PPL_MAXP_VAL) << `PPL_MAXP_LSB)
    | (64'(`PPL_MAXW_VAL) << `PPL_MAXW_LSB);
  wire [63:0] rd_mux =
      hit_limit  ? ctrl_r :
      hit_energy ? 64'(energy_r) :
      hit_throt  ? 64'(throt_r) :
      hit_info   ? info_val :
      hit_unit   ? unit_val : 64'h0;

  // limit-control write
  wire [63:0] wmask = req_in.wdata & `PPL_CTRL_MASK;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_we) begin
      ctrl_nxt = wmask;
      if (W2_FIXED) begin
        ctrl_nxt[`PPL_W2_MSB:`PPL_W2_LSB] = `PPL_W2_FIXED;
      end
    end
  end

  wire [63:0] ctrl_rst = W2_FIXED ?
    (64'(`PPL_W2_FIXED) << `PPL_W2_LSB) : 64'h0;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r <= ctrl_rst;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // register port answer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= 64'h0;
      ack_r   <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      ack_r   <= access;
      fault_r <= access & ~mapped;
      rdata_r <= req_in.rd ? rd_mux : 64'h0;
    end
  end

  // rate dividers
  // both ticks are cycle counts derived from times; tests shorten them
  wire ref_end = ref_cnt_r == 32'(REFRESH_CYC - 1);
  wire tu_end  = tu_cnt_r == 32'(TUNIT_CYC - 1);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ref_cnt_r  <= 32'h0;
      tu_cnt_r   <= 32'h0;
      ref_tick_r <= 1'b0;
      tu_tick_r  <= 1'b0;
    end else begin
      ref_cnt_r  <= ref_end ? 32'h0 : ref_cnt_r + 32'h1;
      tu_cnt_r   <= tu_end ? 32'h0 : tu_cnt_r + 32'h1;
      ref_tick_r <= ref_end;
      tu_tick_r  <= tu_end;
    end
  end

  // energy counter
  // energy gathers in a hidden total and becomes visible once per
  // refresh, so software sees a value that steps at the refresh rate
  wire [CW-1:0] amt = meter_in.energy_vld ?
                      CW'(meter_in.energy_amt) : '0;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pend_r   <= '0;
      energy_r <= '0;
    end else if (ref_tick_r) begin
      pend_r   <= amt;
      energy_r <= energy_r + pend_r;
    end else begin
      pend_r   <= pend_r + amt;
    end
  end

  // window checkers
  ppl_pkg::ppl_limit_s lim [2];
  assign lim[0] = ppl_pkg::ppl_limit_s'(
    ctrl_r[`PPL_L1_LSB +: `PPL_HALF_W]);
  assign lim[1] = ppl_pkg::ppl_limit_s'(
    ctrl_r[`PPL_L2_LSB +: `PPL_HALF_W]);

  logic [1:0] trip;
  logic [1:0] trip_clamp;

  for (genvar g = 0; g < 2; g++) begin : g_win
    logic [CW-1:0] cnt_r;
    logic [47:0]   sum_r;
    logic          over_r;
    wire  [CW-1:0] len = win_len(lim[g].win_exp,
                                 lim[g].win_frac);
    wire  [47:0]   sum_in = sum_r + 48'(meter_in.avg_power);
    wire  [47:0]   budget = 48'(lim[g].ceiling) * 48'(len);
    wire           last = (cnt_r + CW'(1)) >= len;
    always_ff @(posedge clk_in) begin
      if (rst_in || !lim[g].en) begin
        cnt_r     <= '0;
        sum_r     <= 48'h0;
        over_r    <= 1'b0;
      end else if (tu_tick_r) begin
        if (last) begin
          cnt_r     <= '0;
          sum_r     <= 48'h0;
          // average over the window against the ceiling, kept as
          // sum against ceiling times length to avoid a divider
          over_r    <= sum_in > budget;
        end else begin
          cnt_r <= cnt_r + CW'(1);
          sum_r <= sum_in;
        end
      end
    end
    assign trip[g]       = lim[g].en & over_r;
    assign trip_clamp[g] = trip[g] & lim[g].clamp;
  end

  // throttle outputs and accumulator
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      down_r  <= 1'b0;
      below_r <= 1'b0;
      throt_r <= '0;
    end else begin
      down_r  <= |trip;
      below_r <= |trip_clamp;
      // counts only time held below the request by these limits
      if (tu_tick_r && os_below_in && below_r) begin
        throt_r <= throt_r + CW'(1);
      end
    end
  end

  assign rdata_out        = rdata_r;
  assign ack_out          = ack_r;
  assign fault_out        = fault_r;
  assign pstate_down_out  = down_r;
  assign below_req_ok_out = below_r;

  // assertions
  sequence s_lock_write;
    locked && req_in.wr && hit_limit;
  endsequence

  sequence s_ctrl_held;
    $stable(ctrl_r);
  endsequence

  sequence s_unit_read;
    req_in.rd && hit_unit;
  endsequence

  property p_locked_drop;
    @(posedge clk_in) disable iff (rst_in)
    s_lock_write |=> s_ctrl_held;
  endproperty

  lock_holds_a: assert property (p_locked_drop)
    else $error("write changed a locked limit register");

  unit_value_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_unit_read |=> rdata_out[`PPL_PU_MSB:`PPL_PU_LSB] == `PPL_PU_DEF
      && rdata_out[`PPL_ESU_MSB:`PPL_ESU_LSB] == `PPL_ESU_DEF
      && rdata_out[`PPL_TU_MSB:`PPL_TU_LSB] == `PPL_TU_DEF)
    else $error("unit register read wrong scale fields");

  unit_ro_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    req_in.wr && hit_unit ##[1:2] req_in.rd && hit_unit
    |=> rdata_out == unit_val)
    else $error("unit register changed after a write");

  energy_step_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !ref_tick_r |=> $stable(energy_r))
    else $error("energy counter moved between refreshes");

  energy_high_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    req_in.rd && hit_energy |=> rdata_out[63:CW] == '0)
    else $error("energy counter upper bits not zero");

  policy_fault_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    req_in.rd && req_in.idx == abs_idx(`PPL_REL_POLICY)
    |=> fault_out && ack_out && rdata_out == 64'h0)
    else $error("reserved slot did not fault");

  throt_gate_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !(tu_tick_r && os_below_in && below_r) |=> $stable(throt_r))
    else $error("throttled time moved while not limited");

  clamp_need_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    below_req_ok_out |-> $past(|(trip & {lim[1].clamp, lim[0].clamp})))
    else $error("below-request allowed without clamp");

  down_enable_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !lim[0].en && !lim[1].en ##1 !lim[0].en && !lim[1].en
    |-> !pstate_down_out)
    else $error("throttle asserted with both limits off");

  w2_fixed_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    W2_FIXED |-> ctrl_r[`PPL_W2_MSB:`PPL_W2_LSB] == `PPL_W2_FIXED)
    else $error("hard-wired second window changed");

  reserved_zero_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (ctrl_r & ~`PPL_CTRL_MASK) == 64'h0)
    else $error("reserved control bits set");

  ctrl_write_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ctrl_we && !W2_FIXED |=> ctrl_r == $past(wmask))
    else $error("unlocked write not stored");

  lock_sticky_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    locked |=> locked)
    else $error("lock bit cleared without reset");

  throt_step_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    tu_tick_r && os_below_in && below_r
    |=> throt_r == $past(throt_r) + CW'(1))
    else $error("throttled time missed a limited tick");

  ack_follows_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    access |=> ack_out)
    else $error("request not acknowledged");

  idle_quiet_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !access |=> !ack_out && !fault_out && rdata_out == 64'h0)
    else $error("answer given without a request");

  unmapped_fault_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    access && !mapped |=> fault_out && rdata_out == 64'h0)
    else $error("unmapped index did not fault");
endmodule : ppl_limit_regs

// file: testbench/test_ppl_limit_regs.sv
// self-checking bench for the package power limit register block
`timescale 1ns/10ps
`include "ppl_regs.svh"
`define CHK(nm, exp, got) \
  compares += 1; \
  if ((got) !== (exp)) begin \
    n_errors += 1; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
  end
module test_ppl_limit_regs;
  logic                clk_in;
  logic                rst_in;
  ppl_pkg::ppl_req_s   req;
  ppl_pkg::ppl_meter_s meter;
  logic                os_below;
  logic [63:0]         rdata;
  logic                ack;
  logic                fault;
  logic                pdown;
  logic                below_ok;
  logic [63:0]         rdata_fix;
  logic [63:0]         q_fix;
  int                  n_errors;
  int                  compares;
  logic [63:0]         q;
  logic [63:0]         q1;
  logic                f;
  logic [7:0]          bad_idx [3];
  logic [7:0]          good_idx [5];

  // short refresh and time-unit counts keep the run brief
  ppl_limit_regs #(.REFRESH_CYC(8), .TUNIT_CYC(4), .W2_FIXED(1'b0)) i_dut (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .req_in           (req),
    .meter_in         (meter),
    .os_below_in      (os_below),
    .rdata_out        (rdata),
    .ack_out          (ack),
    .fault_out        (fault),
    .pstate_down_out  (pdown),
    .below_req_ok_out (below_ok)
  );

  // second copy with the second window hard-wired; only its data is read
  ppl_limit_regs #(.REFRESH_CYC(8), .TUNIT_CYC(4), .W2_FIXED(1'b1)) i_fix (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .req_in           (req),
    .meter_in         (meter),
    .os_below_in      (os_below),
    .rdata_out        (rdata_fix),
    .ack_out          (),
    .fault_out        (),
    .pstate_down_out  (),
    .below_req_ok_out ()
  );

  initial clk_in = 1'b0;
  always #2 clk_in = ~clk_in;

  task automatic acc(input logic w, input logic [7:0] i,
                     input logic [63:0] d, output logic [63:0] qo,
                     output logic fo);
    @(posedge clk_in);
    req <= '{rd: ~w, wr: w, idx: i, wdata: d};
    @(posedge clk_in);
    req <= '0;
    #1;
    `CHK("ack", 1'b1, ack)
    qo = rdata;
    q_fix = rdata_fix;
    fo = fault;
  endtask : acc

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic do_reset();
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask : do_reset

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_cyc

  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors += 1;
    end_of_test();
  end

  initial begin
    rst_in   = 1'b1;
    req      = '0;
    meter    = '0;
    os_below = 1'b0;
    n_errors = 0;
    compares = 0;
    bad_idx  = '{8'h12, 8'h20, 8'h05};
    good_idx = '{8'h06, 8'h10, 8'h11, 8'h13, 8'h14};
    do_reset();
    // unit scale defaults, then a write that must not stick
    acc(1'b0, 8'h06, 64'h0, q, f);
    `CHK("unit", 64'h0000_0000_000A_1003, q)
    acc(1'b1, 8'h06, '1, q, f);
    acc(1'b0, 8'h06, 64'h0, q, f);
    `CHK("unit_ro", 64'h0000_0000_000A_1003, q)
    foreach (bad_idx[k]) begin
      acc(1'b0, bad_idx[k], 64'h0, q, f);
      `CHK("bad_fault", 1'b1, f)
      `CHK("bad_data", 64'h0, q)
    end
    foreach (good_idx[k]) begin
      acc(1'b0, good_idx[k], 64'h0, q, f);
      `CHK("good_fault", 1'b0, f)
    end
    acc(1'b0, 8'h14, 64'h0, q, f);
    `CHK("range", 64'h0020_0400_0100_0280, q)
    acc(1'b0, 8'h13, 64'h0, q, f);
    `CHK("thr_rst", 64'h0, q)
    // energy: five samples accumulate, writes dropped
    repeat (5) begin
      @(posedge clk_in);
      meter <= '{energy_vld: 1'b1, energy_amt: 16'h1234, avg_power: 15'h0};
    end
    @(posedge clk_in);
    meter <= '0;
    acc(1'b1, 8'h11, '1, q, f);
    wait_cyc(40);
    acc(1'b0, 8'h11, 64'h0, q, f);
    `CHK("energy", 64'h0000_0000_0000_5B04, q)
    // limit one: ceiling 10, window two ticks, clamp allowed
    acc(1'b1, 8'h10, 64'h0000_0000_0003_800A, q, f);
    acc(1'b0, 8'h10, 64'h0, q, f);
    `CHK("ctrl1", 64'h0000_0000_0003_800A, q)
    `CHK("w2_fix", 64'h0014_0000_0003_800A, q_fix)
    @(posedge clk_in);
    meter    <= '{energy_vld: 1'b0, energy_amt: 16'h0, avg_power: 15'h0014};
    os_below <= 1'b1;
    wait_cyc(40);
    `CHK("pdown1", 1'b1, pdown)
    `CHK("below1", 1'b1, below_ok)
    acc(1'b0, 8'h13, 64'h0, q, f);
    `CHK("thr_run", 1'b1, q[31:0] != 32'h0)
    `CHK("thr_hi", 32'h0, q[63:32])
    @(posedge clk_in);
    os_below <= 1'b0;
    wait_cyc(3);
    acc(1'b0, 8'h13, 64'h0, q1, f);
    wait_cyc(20);
    acc(1'b0, 8'h13, 64'h0, q, f);
    `CHK("thr_hold", q1, q)
    // clamp withdrawn: still lowered, but not below request
    acc(1'b1, 8'h10, 64'h0000_0000_0002_800A, q, f);
    wait_cyc(40);
    `CHK("pdown2", 1'b1, pdown)
    `CHK("below2", 1'b0, below_ok)
    // average equal to ceiling stays within the limit
    @(posedge clk_in);
    meter <= '{energy_vld: 1'b0, energy_amt: 16'h0, avg_power: 15'h000A};
    wait_cyc(40);
    `CHK("pdown_eq", 1'b0, pdown)
    // limit two alone
    acc(1'b1, 8'h10, 64'h0002_800A_0000_0000, q, f);
    @(posedge clk_in);
    meter <= '{energy_vld: 1'b0, energy_amt: 16'h0, avg_power: 15'h0014};
    wait_cyc(40);
    `CHK("pdown_l2", 1'b1, pdown)
    acc(1'b1, 8'h10, 64'h0, q, f);
    wait_cyc(3);
    `CHK("pdown_off", 1'b0, pdown)
    // lock: reserved bits dropped, later writes ignored until reset
    @(posedge clk_in);
    meter <= '0;
    acc(1'b1, 8'h10, '1, q, f);
    acc(1'b0, 8'h10, 64'h0, q, f);
    `CHK("ctrl_mask", `PPL_CTRL_MASK, q)
    `CHK("w2_fix_all", 64'h8015_FFFF_00FF_FFFF, q_fix)
    acc(1'b1, 8'h10, 64'h0, q, f);
    acc(1'b0, 8'h10, 64'h0, q, f);
    `CHK("locked", `PPL_CTRL_MASK, q)
    do_reset();
    acc(1'b0, 8'h10, 64'h0, q, f);
    `CHK("unlocked", 64'h0, q)
    `CHK("w2_fix_rst", 64'h0014_0000_0000_0000, q_fix)
    acc(1'b1, 8'h10, 64'h0000_0000_0000_0005, q, f);
    acc(1'b0, 8'h10, 64'h0, q, f);
    `CHK("rewrite", 64'h0000_0000_0000_0005, q)
    end_of_test();
  end
endmodule : test_ppl_limit_regs
